/* File: include/cpu_regs_map.svh */
// constants of the core register stack: addresses, widths, vectors
// assumes inclusion by bare name from the package and the core
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

`define DATA_W          8
`define ADDR_W          8
`define PC_W            12
`define STACK_LEVELS    6
`define DEPTH_W         3

`define ADDR_POINTER_1  8'h80
`define ADDR_POINTER_2  8'h81
`define ADDR_SHORT_1    8'h82
`define ADDR_SHORT_2    8'h83
`define ADDR_SUM        8'hff

`define RESET_VECTOR    12'hffe
`define URGENT_VECTOR   12'hffc
`define DATA_RESET      8'h00
`define PC_ONE          12'h001
`define PC_ZERO         12'h000
`define DEPTH_ZERO      3'h0
`define DEPTH_ONE       3'h1
`define DEPTH_FULL      3'h6
`define OFFSET_SIGN     7
`define FLAGS_RESET     3'h0

`endif

/* File: include/cpu_regs_pkg.sv */
// types of the core register stack
// assumes cpu_regs_map.svh on the include path
`include "cpu_regs_map.svh"

package cpu_regs_pkg;

    typedef enum logic [1:0] {
        CTX_NORMAL,
        CTX_IRQ,
        CTX_URGENT
    } ctx_t;

    typedef logic [`PC_W-1:0] pc_word_t;

    typedef struct packed {
        logic [`DATA_W-1:0]                 sum;
        logic [`DATA_W-1:0]                 ptr1;
        logic [`DATA_W-1:0]                 ptr2;
        logic [`DATA_W-1:0]                 slot1;
        logic [`DATA_W-1:0]                 slot2;
        pc_word_t                           pc;
        logic [`STACK_LEVELS-1:0][`PC_W-1:0] stack;
        logic [`DEPTH_W-1:0]                depth;
        ctx_t                               ctx;
        ctx_t                               ctx_prev;
        logic [2:0]                         carry;
        logic [2:0]                         zero;
        logic                               cur_carry;
        logic                               cur_zero;
        logic [`DATA_W-1:0]                 rdata;
        logic                               rhit;
    } state_t;

endpackage : cpu_regs_pkg

/* File: core/cpu_core_register_stack.sv */
// programmer-visible registers, program counter, flag banks and
// six-level return stack of an 8-bit core
// assumes the sequencer raises at most one pc control per cycle and
// drives alu results on the same clock
//
// Summary of operation
// - 8-bit accumulator, also data address ffh
// - two pointers mirrored at 80h and 81h
// - two short slots mirrored at 82h, 83h
// - program counter is 12 bits wide
// - ordinary instruction advances counter by one
// - relative branch adds signed offset to counter
// - counter loads target, vector, reset, popped value
// - three flag pairs, only current context used
// - interrupt entry switches pair, return restores
// - pairs keep values across context switches
// - carry from arithmetic, bit test, rotate
// - zero set when result equals zero
// - reset selects urgent context flag pair
// - six 12-bit stack levels, no pointer
// - push shifts levels deeper, pc enters top
// - pop moves top into pc, levels rise
// - overflow keeps deepest position, oldest lost
// - empty-stack return continues with next instruction
// - stack holds return addresses only
// - reset clears stack, pc at 0ffeh
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"

module cpu_core_register_stack
    import cpu_regs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [`ADDR_W-1:0]  ds_addr,
    input  wire logic                ds_wr,
    input  wire logic                ds_rd,
    input  wire logic [`DATA_W-1:0]  ds_wdata,
    input  wire logic                alu_wr,
    input  wire logic [`DATA_W-1:0]  alu_result,
    input  wire logic                zero_wr,
    input  wire logic                carry_wr,
    input  wire logic                carry_val,
    input  wire logic                pc_inc,
    input  wire logic                branch,
    input  wire logic [`DATA_W-1:0]  branch_offset,
    input  wire logic                jump_op,
    input  wire logic                call_op,
    input  wire logic [`PC_W-1:0]    target,
    input  wire logic                irq_enter,
    input  wire logic [`PC_W-1:0]    irq_vector,
    input  wire logic                urgent_enter,
    input  wire logic                return_sub,
    input  wire logic                return_int,
    output logic [`DATA_W-1:0]       sum_register,
    output logic [`DATA_W-1:0]       pointer_1,
    output logic [`DATA_W-1:0]       pointer_2,
    output logic [`DATA_W-1:0]       short_slot_1,
    output logic [`DATA_W-1:0]       short_slot_2,
    output logic [`PC_W-1:0]         pc,
    output logic                     cur_carry,
    output logic                     cur_zero,
    output ctx_t                     context_now,
    output logic [`DEPTH_W-1:0]      stack_depth,
    output logic [`DATA_W-1:0]       ds_rdata,
    output logic                     ds_hit
);

    // ************************************************************
    // state
    // ************************************************************
    state_t state_reg;
    state_t state_next;

    pc_word_t offset_ext;
    logic     do_push;
    logic     do_pop;
    logic     rd_hit;

    // sign-extend so a backward branch wraps in 12 bits
    assign offset_ext = {{(`PC_W-`DATA_W){branch_offset[`OFFSET_SIGN]}},
                         branch_offset};
    assign do_push    = irq_enter | urgent_enter | call_op;
    assign do_pop     = return_sub | return_int;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        rd_hit     = 1'b0;

        // alu results land in the accumulator
        if (alu_wr)
        begin
            state_next.sum = alu_result;
        end

        // data-space mirrors; a direct write wins over the alu
        if (ds_wr)
        begin
            case (ds_addr)
                `ADDR_SUM:       state_next.sum   = ds_wdata;
                `ADDR_POINTER_1: state_next.ptr1  = ds_wdata;
                `ADDR_POINTER_2: state_next.ptr2  = ds_wdata;
                `ADDR_SHORT_1:   state_next.slot1 = ds_wdata;
                `ADDR_SHORT_2:   state_next.slot2 = ds_wdata;
                default:         state_next.sum   = state_next.sum;
            endcase
        end

        // reads answer one cycle later, flags and stack untouched
        state_next.rdata = `DATA_RESET;
        if (ds_rd)
        begin
            rd_hit = 1'b1;
            case (ds_addr)
                `ADDR_SUM:       state_next.rdata = state_reg.sum;
                `ADDR_POINTER_1: state_next.rdata = state_reg.ptr1;
                `ADDR_POINTER_2: state_next.rdata = state_reg.ptr2;
                `ADDR_SHORT_1:   state_next.rdata = state_reg.slot1;
                `ADDR_SHORT_2:   state_next.rdata = state_reg.slot2;
                default:         rd_hit = 1'b0;
            endcase
        end
        state_next.rhit = rd_hit;

        // flags of the active context only
        // a same-cycle switch still lands them in the old bank
        case (state_reg.ctx)
            CTX_NORMAL:
            begin
                if (carry_wr)
                    state_next.carry[0] = carry_val;
                if (zero_wr)
                    state_next.zero[0] = alu_result == `DATA_RESET;
            end
            CTX_IRQ:
            begin
                if (carry_wr)
                    state_next.carry[1] = carry_val;
                if (zero_wr)
                    state_next.zero[1] = alu_result == `DATA_RESET;
            end
            CTX_URGENT:
            begin
                if (carry_wr)
                    state_next.carry[2] = carry_val;
                if (zero_wr)
                    state_next.zero[2] = alu_result == `DATA_RESET;
            end
            default:
            begin
                state_next.carry = state_reg.carry;
            end
        endcase

        // program counter and stack; entry has highest priority
        if (do_push)
        begin
            // only the return address is saved, never data registers
            for (int i = `STACK_LEVELS-1; i > 0; i--)
            begin
                state_next.stack[i] = state_reg.stack[i-1];
            end
            state_next.stack[0] = state_reg.pc;
            // deepest level drops out silently; no overflow flag
            if (state_reg.depth != `DEPTH_FULL)
            begin
                state_next.depth = state_reg.depth + `DEPTH_ONE;
            end
            else
            begin
                state_next.depth = `DEPTH_FULL;
            end
            if (urgent_enter)
            begin
                state_next.pc       = `URGENT_VECTOR;
                state_next.ctx_prev = state_reg.ctx;
                state_next.ctx      = CTX_URGENT;
            end
            else if (irq_enter)
            begin
                state_next.pc       = irq_vector;
                state_next.ctx_prev = state_reg.ctx;
                state_next.ctx      = CTX_IRQ;
            end
            else
            begin
                state_next.pc = target;
            end
        end
        else if (jump_op)
        begin
            state_next.pc = target;
        end
        else if (do_pop)
        begin
            if (state_reg.depth == `DEPTH_ZERO)
            begin
                // empty stack: fall through to the next instruction
                state_next.pc = state_reg.pc + `PC_ONE;
            end
            else
            begin
                state_next.pc = state_reg.stack[0];
                for (int i = 0; i < `STACK_LEVELS-1; i++)
                begin
                    state_next.stack[i] = state_reg.stack[i+1];
                end
                // vacated deepest level reads back as zero
                state_next.stack[`STACK_LEVELS-1] = `PC_ZERO;
                state_next.depth = state_reg.depth - `DEPTH_ONE;
            end
            if (return_int)
            begin
                // one level of history; deeper nesting returns to normal
                state_next.ctx      = state_reg.ctx_prev;
                state_next.ctx_prev = CTX_NORMAL;
            end
        end
        else if (branch)
        begin
            state_next.pc = state_reg.pc + offset_ext;
        end
        else if (pc_inc)
        begin
            state_next.pc = state_reg.pc + `PC_ONE;
        end

        // visible pair follows the new context; banks cleared only by reset
        case (state_next.ctx)
            CTX_NORMAL:
            begin
                state_next.cur_carry = state_next.carry[0];
                state_next.cur_zero  = state_next.zero[0];
            end
            CTX_IRQ:
            begin
                state_next.cur_carry = state_next.carry[1];
                state_next.cur_zero  = state_next.zero[1];
            end
            default:
            begin
                state_next.cur_carry = state_next.carry[2];
                state_next.cur_zero  = state_next.zero[2];
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset starts in the urgent context at the reset vector
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.sum       <= `DATA_RESET;
            state_reg.ptr1      <= `DATA_RESET;
            state_reg.ptr2      <= `DATA_RESET;
            state_reg.slot1     <= `DATA_RESET;
            state_reg.slot2     <= `DATA_RESET;
            state_reg.pc        <= `RESET_VECTOR;
            state_reg.stack     <= '0;
            state_reg.depth     <= `DEPTH_ZERO;
            state_reg.ctx       <= CTX_URGENT;
            state_reg.ctx_prev  <= CTX_NORMAL;
            state_reg.carry     <= `FLAGS_RESET;
            state_reg.zero      <= `FLAGS_RESET;
            state_reg.cur_carry <= 1'b0;
            state_reg.cur_zero  <= 1'b0;
            state_reg.rdata     <= `DATA_RESET;
            state_reg.rhit      <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign sum_register = state_reg.sum;
    assign pointer_1    = state_reg.ptr1;
    assign pointer_2    = state_reg.ptr2;
    assign short_slot_1 = state_reg.slot1;
    assign short_slot_2 = state_reg.slot2;
    assign pc           = state_reg.pc;
    assign cur_carry    = state_reg.cur_carry;
    assign cur_zero     = state_reg.cur_zero;
    assign context_now  = state_reg.ctx;
    assign stack_depth  = state_reg.depth;
    assign ds_rdata     = state_reg.rdata;
    assign ds_hit       = state_reg.rhit;

endmodule : cpu_core_register_stack

`default_nettype wire

/* File: test/cpu_alu_partner.sv */
// adder standing in for the core alu beside the register stack
// assumes the bench applies operands and flag strobes itself
`timescale 1ns/1ps
`default_nettype none
// ****
// alu partner
// ****
module cpu_alu_partner
(
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    output logic [7:0]      result,
    output logic            carry
);
    // carry out of the byte add feeds the carry flag
    assign {carry, result} = {1'b0, op_a} + {1'b0, op_b};
endmodule : cpu_alu_partner
`default_nettype wire

/* File: test/cpu_core_register_stack_asserts.sv */
// timing checks on the register stack ports
// assumes the map header on the include path, bound into the core
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"
// ****
// checker
// ****
module cpu_core_register_stack_asserts
    import cpu_regs_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic [`ADDR_W-1:0] ds_addr,
    input wire logic               ds_wr,
    input wire logic               ds_rd,
    input wire logic [`DATA_W-1:0] ds_wdata,
    input wire logic [`DATA_W-1:0] alu_result,
    input wire logic               zero_wr,
    input wire logic               carry_wr,
    input wire logic               pc_inc,
    input wire logic               branch,
    input wire logic               jump_op,
    input wire logic               call_op,
    input wire logic [`PC_W-1:0]   target,
    input wire logic               irq_enter,
    input wire logic               urgent_enter,
    input wire logic               return_sub,
    input wire logic               return_int,
    input wire logic [`DATA_W-1:0] sum_register,
    input wire logic [`DATA_W-1:0] pointer_1,
    input wire logic [`PC_W-1:0]   pc,
    input wire logic               cur_carry,
    input wire logic               cur_zero,
    input wire ctx_t               context_now,
    input wire logic [`DEPTH_W-1:0] stack_depth,
    input wire logic [`DATA_W-1:0] ds_rdata,
    input wire logic               ds_hit
);
    wire logic push;
    wire logic hi;
    assign push = urgent_enter | irq_enter | call_op;
    assign hi = push | jump_op | return_sub | return_int | branch;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pc_step: assert property (
        pc_inc && !hi |=> pc == $past(pc) + 12'h001)
        else $error("pc did not step by one");
    a_call_target: assert property (
        call_op && !urgent_enter && !irq_enter |=> pc == $past(target))
        else $error("call target not loaded");
    a_push_depth: assert property (
        push && stack_depth != 3'h6
        |=> stack_depth == $past(stack_depth) + 3'h1)
        else $error("push depth");
    a_depth_full: assert property (
        push && stack_depth == 3'h6 |=> stack_depth == 3'h6)
        else $error("depth left full level");
    a_urgent_vec: assert property (
        urgent_enter |=> pc == 12'hffc && context_now == CTX_URGENT)
        else $error("urgent");
    a_sum_write: assert property (
        ds_wr && ds_addr == 8'hff |=> sum_register == $past(ds_wdata))
        else $error("sum write");
    a_read_ptr: assert property (
        ds_rd && ds_addr == 8'h80
        |=> ds_hit && ds_rdata == $past(pointer_1))
        else $error("ptr read");
    a_no_read: assert property (
        !ds_rd |=> !ds_hit && ds_rdata == 8'h00)
        else $error("read data without read");
    a_zero_flag: assert property (
        zero_wr && !push && !return_int
        |=> cur_zero == ($past(alu_result) == 8'h00))
        else $error("zero");
    a_pop_empty: assert property (
        return_sub && stack_depth == 3'h0 && !push && !jump_op
        |=> pc == $past(pc) + 12'h001 && stack_depth == 3'h0)
        else $error("empty pop");
    a_mirror_quiet: assert property (
        ds_wr && !hi && !pc_inc && !zero_wr && !carry_wr
        |=> $stable(stack_depth) && $stable(cur_carry))
        else $error("mirror write moved stack or flag");
    c_full_push: cover property (call_op && stack_depth == 3'h6);
    c_irq: cover property (irq_enter);
    c_ret_int: cover property (return_int);
endmodule : cpu_core_register_stack_asserts
bind cpu_core_register_stack cpu_core_register_stack_asserts i_chk (
    .clk(clk), .rst_n(rst_n), .ds_addr(ds_addr), .ds_wr(ds_wr),
    .ds_rd(ds_rd), .ds_wdata(ds_wdata), .alu_result(alu_result),
    .zero_wr(zero_wr), .carry_wr(carry_wr), .pc_inc(pc_inc),
    .branch(branch), .jump_op(jump_op), .call_op(call_op),
    .target(target), .irq_enter(irq_enter), .urgent_enter(urgent_enter),
    .return_sub(return_sub), .return_int(return_int),
    .sum_register(sum_register), .pointer_1(pointer_1), .pc(pc),
    .cur_carry(cur_carry), .cur_zero(cur_zero),
    .context_now(context_now), .stack_depth(stack_depth),
    .ds_rdata(ds_rdata), .ds_hit(ds_hit));
`default_nettype wire

/* File: test/cpu_core_register_stack_tb.sv */
// sequence tests of the register stack through its own strobes
// assumes package, header, design, checker and alu partner compiled
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module cpu_core_register_stack_tb;
    import cpu_regs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  op_a = 8'h00;
    logic [7:0]  op_b = 8'h00;
    logic [2:0]  fl = 3'h0;
    logic [7:0]  ctl = 8'h00;
    logic [11:0] tgt = 12'h000;
    logic [7:0]  res;
    logic        cy;
    logic [7:0]  sum, p1, p2, s1, s2, rdata;
    logic [11:0] pc;
    logic        c_f, z_f, hit;
    ctx_t        ctx;
    logic [2:0]  depth;
    logic [7:0]  map [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    cpu_alu_partner i_cpu_alu_partner (.op_a(op_a), .op_b(op_b),
        .result(res), .carry(cy));
    cpu_core_register_stack i_cpu_core_register_stack (.clk(clk),
        .rst_n(rst_n), .ds_addr(addr), .ds_wr(wr), .ds_rd(rd),
        .ds_wdata(wdata), .alu_wr(fl[2]), .alu_result(res),
        .zero_wr(fl[1]), .carry_wr(fl[0]), .carry_val(cy),
        .pc_inc(ctl[0]), .branch(ctl[1]), .branch_offset(tgt[7:0]),
        .jump_op(ctl[4]), .call_op(ctl[5]), .target(tgt),
        .irq_enter(ctl[6]), .irq_vector(tgt), .urgent_enter(ctl[7]),
        .return_sub(ctl[3]), .return_int(ctl[2]), .sum_register(sum),
        .pointer_1(p1), .pointer_2(p2), .short_slot_1(s1),
        .short_slot_2(s2), .pc(pc), .cur_carry(c_f), .cur_zero(z_f),
        .context_now(ctx), .stack_depth(depth), .ds_rdata(rdata),
        .ds_hit(hit));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // the bus, op and alu tasks end 1 ns past the answering edge so outputs are settled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask : bus
    task automatic op(input logic [7:0] c, input logic [11:0] t);
        @(posedge clk);
        ctl <= c;
        tgt <= t;
        @(posedge clk);
        ctl <= 8'h00;
        #1;
    endtask : op
    task automatic alu(input logic [7:0] a, input logic [7:0] b,
                       input logic [2:0] f);
        @(posedge clk);
        op_a <= a;
        op_b <= b;
        fl <= f;
        @(posedge clk);
        fl <= 3'h0;
        #1;
    endtask : alu
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(pc, 12'hffe);
        chk(depth, 3'h0);
        chk(ctx, CTX_URGENT);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
            bus(1'b1, map[i], map[i] ^ 8'h5a);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, map[i], 8'h00);
            chk({hit, rdata}, {1'b1, map[i]^8'h5a});
        end
        chk({p1, p2, s1, s2}, 32'hdadbd8d9);
        bus(1'b1, 8'h84, 8'h77);
        bus(1'b0, 8'h84, 8'h00);
        chk({hit, rdata, sum}, {1'b0, 8'h00, 8'ha5});
        $display("test registers done");
        op(8'h01, 12'h000);
        chk(pc, 12'hfff);
        op(8'h01, 12'h000);
        chk(pc, 12'h000);
        op(8'h10, 12'h123);
        chk(pc, 12'h123);
        op(8'h02, 12'h0fe);
        chk(pc, 12'h121);
        op(8'h02, 12'h005);
        chk(pc, 12'h126);
        $display("test counter done");
        for (int i = 0; i < 7; i++)
            op(8'h20, 12'h100 + 12'(i));
        chk({depth, pc}, {3'h6, 12'h106});
        for (int i = 0; i < 6; i++)
        begin
            op(8'h08, 12'h000);
            chk(pc, 12'h105 - 12'(i));
        end
        op(8'h08, 12'h000);
        chk({depth, pc}, {3'h0, 12'h101});
        chk(sum, 8'ha5);
        $display("test stack done");
        alu(8'hff, 8'h01, 3'h7);
        chk({sum, c_f, z_f}, {8'h00, 2'b11});
        op(8'h40, 12'h200);
        chk({ctx, pc, c_f, z_f}, {CTX_IRQ, 12'h200, 2'b00});
        alu(8'hff, 8'h02, 3'h3);
        chk({c_f, z_f}, 2'b10);
        op(8'h04, 12'h000);
        chk({ctx,pc,c_f,z_f}, {CTX_URGENT, 12'h101, 2'b11});
        op(8'h04, 12'h000);
        chk({ctx, c_f, z_f}, {CTX_NORMAL, 2'b00});
        op(8'h40, 12'h300);
        chk({ctx, depth, c_f, z_f}, {CTX_IRQ, 3'h1, 2'b10});
        op(8'h80, 12'h000);
        chk({ctx,pc,c_f,z_f}, {CTX_URGENT, 12'hffc, 2'b11});
        $display("test flags done");
        // two edges so the checker sees the urgent entry settle
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk({ctx,p1,depth,pc}, {CTX_URGENT, 8'h00, 3'h0, 12'hffe});
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({ctx,c_f,z_f,depth}, {CTX_URGENT, 2'b00, 3'h0});
        @(posedge clk);
        #1;
        chk(pc, 12'hffe);
        $display("test second reset done");
        end_of_test();
    end
endmodule : cpu_core_register_stack_tb
`default_nettype wire
